// file: inc/birc_params.svh
// Constants for the burst instruction memory controller
`ifndef BIRC_PARAMS_SVH
`define BIRC_PARAMS_SVH
`define BIRC_CNT_W 8
`define BIRC_CNT_LO_W 5
`define BIRC_LATCH_W 9
`define BIRC_WADDR_W 17
`define BIRC_PADDR_W 19
`define BIRC_CNT_LSB 2
`define BIRC_LATCH_LSB 10
`define BIRC_DATA_W 32
`define BIRC_FIFO_DEPTH 8
`endif

// file: inc/birc_pkg.sv
// Types for the burst instruction memory controller
package birc_pkg;
  typedef enum logic {BIRC_IDLE, BIRC_ACCESS} birc_state_e;
endpackage

// file: inc/birc_if.sv
// Instruction bus between processor end and memory controller
`timescale 1ns/1ps
`default_nettype none
`include "birc_params.svh"
interface birc_if;
  logic instr_req_n;
  logic burst_req_n;
  logic burst_ack_n;
  logic instr_ready_n;
  logic invalidate_n;
  logic [`BIRC_PADDR_W-1:0] addr;
  logic [`BIRC_DATA_W-1:0] instr;
  modport ctrl (
    input instr_req_n, burst_req_n, invalidate_n, addr,
    output burst_ack_n, instr_ready_n, instr
  );
  modport cpu (
    output instr_req_n, burst_req_n, invalidate_n, addr,
    input burst_ack_n, instr_ready_n, instr
  );
endinterface
`default_nettype wire

// file: hw/birc_fifo.sv
// Small synchronous FIFO for fetched instructions
`timescale 1ns/1ps
`default_nettype none
module birc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// file: hw/birc_ctrl.sv
// Memory controller end: access state, burst counter, upper latch
// Behaviour
// R1: Idle to access on request without invalidate
// R2: Stay in access while burst requested
// R3: Resume burst from idle without new address
// R4: Access bit drives chip enable and ready
// R5: Burst acknowledge is registered burst request
// R6: Dropped acknowledge ends burst; new request needed (here burst request alone resumes from idle after ack drops)
// R7: Load counter on valid new address
// R8: Counter increments each access clock
// R9: Counter holds when idle without request
// R10: Five-bit carry increments upper three bits
// R11: Upper bits latched on load, else held
// R12: Counter split five low, three high
// R13: Latch covers 128K words of memory
// R14: Processor handshake signals are active low
// R15: No access starts while invalidate asserted
// R16: Resumed burst continues from held address
// R17: Read-only instruction path, no data path
// R18: Reset clears access, ready, acknowledge
// R19: Counter low, latch high form word address
`timescale 1ns/1ps
`default_nettype none
`include "birc_params.svh"
module birc_ctrl
  import birc_pkg::*;
#(
  parameter int CNT_LO_W = `BIRC_CNT_LO_W,
  parameter int LATCH_W = `BIRC_LATCH_W
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  birc_if.ctrl bus,
  output logic mem_ce_n_o,
  output logic [`BIRC_WADDR_W-1:0] mem_addr_o,
  input wire logic [`BIRC_DATA_W-1:0] mem_data_i
);
  birc_state_e state_q;
  logic [`BIRC_CNT_W-1:0] cnt_q;
  logic [LATCH_W-1:0] latch_q;
  logic burst_ack_n_q;
  logic req;
  logic breq;
  logic inval;
  logic load;
  logic carry_lo;
  logic [`BIRC_CNT_W-1:0] cnt_d;
  // Processor strobes are active low; decode once here
  assign req = !bus.instr_req_n; // R14
  assign breq = !bus.burst_req_n; // R14
  assign inval = !bus.invalidate_n; // R14
  assign load = req && !inval && (state_q == BIRC_IDLE); // R7 R15
  assign carry_lo = &cnt_q[CNT_LO_W-1:0]; // R10
  // Low part counts freely; upper part increments only on full carry
  always_comb begin
    cnt_d[CNT_LO_W-1:0] = cnt_q[CNT_LO_W-1:0] + CNT_LO_W'(1); // R12
    cnt_d[`BIRC_CNT_W-1:CNT_LO_W] = cnt_q[`BIRC_CNT_W-1:CNT_LO_W]
      + (`BIRC_CNT_W-CNT_LO_W)'(carry_lo); // R10 R12
  end
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= BIRC_IDLE; // R18
    end else begin
      case (state_q)
        BIRC_IDLE: begin
          if (!inval && (req || breq)) begin
            state_q <= BIRC_ACCESS; // R1 R3 R15
          end
        end
        BIRC_ACCESS: begin
          if (!breq) begin
            state_q <= BIRC_IDLE; // R2 R6
          end
        end
        default: begin
          state_q <= BIRC_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      burst_ack_n_q <= 1'b1; // R18
    end else begin
      burst_ack_n_q <= bus.burst_req_n; // R5 R6
    end
  end
  // Counter keeps its value across a suspended burst so resume needs no address
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= bus.addr[`BIRC_CNT_LSB +: `BIRC_CNT_W]; // R7
    end else if (state_q == BIRC_ACCESS) begin
      cnt_q <= cnt_d; // R8 R16
    end
  end
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      latch_q <= '0;
    end else if (load) begin
      latch_q <= bus.addr[`BIRC_LATCH_LSB +: LATCH_W]; // R11 R13
    end
  end
  assign mem_ce_n_o = (state_q != BIRC_ACCESS); // R4
  assign bus.instr_ready_n = (state_q != BIRC_ACCESS); // R4
  assign bus.burst_ack_n = burst_ack_n_q;
  assign mem_addr_o = {latch_q, cnt_q}; // R19
  // Only memory data is returned; no data-bus path exists
  assign bus.instr = mem_data_i; // R17
endmodule
`default_nettype wire

// file: hw/birc_cpu.sv
// Processor end: issues fetches and buffers returned instructions
`timescale 1ns/1ps
`default_nettype none
`include "birc_params.svh"
module birc_cpu
  import birc_pkg::*;
#(
  parameter int DEPTH = `BIRC_FIFO_DEPTH
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  birc_if.cpu bus,
  input wire logic fetch_i,
  input wire logic burst_i,
  input wire logic cancel_i,
  input wire logic [`BIRC_PADDR_W-1:0] fetch_addr_i,
  output logic instr_valid_o,
  input wire logic instr_ready_i,
  output logic [`BIRC_DATA_W-1:0] instr_o
);
  logic req_n_q;
  logic breq_n_q;
  logic inval_n_q;
  logic [`BIRC_PADDR_W-1:0] addr_q;
  localparam int FW = $clog2(DEPTH) + 1;
  logic fifo_ready;
  logic busy_q;
  logic [FW-1:0] fill_q;
  logic fill_in;
  logic fill_out;
  logic room;
  // Two words still land after burst request drops, so keep that margin
  assign fill_in = !bus.instr_ready_n && fifo_ready;
  assign fill_out = instr_valid_o && instr_ready_i;
  assign room = (fill_q < FW'(DEPTH - 2));
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fill_q <= '0;
    end else begin
      fill_q <= fill_q + FW'(fill_in) - FW'(fill_out);
    end
  end
  // Hold off new fetch while the buffer cannot take more
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_n_q <= 1'b1;
      breq_n_q <= 1'b1;
      inval_n_q <= 1'b1;
      addr_q <= '0;
      busy_q <= 1'b0;
    end else begin
      inval_n_q <= !cancel_i; // R15
      req_n_q <= 1'b1;
      if (fetch_i && fifo_ready && !busy_q) begin
        req_n_q <= 1'b0; // R6 R14
        addr_q <= fetch_addr_i;
        busy_q <= 1'b1;
      end
      breq_n_q <= !(burst_i && room); // R6 R16
      if (bus.instr_ready_n == 1'b0 || cancel_i) begin
        busy_q <= 1'b0;
      end
    end
  end
  assign bus.instr_req_n = req_n_q;
  assign bus.burst_req_n = breq_n_q;
  assign bus.invalidate_n = inval_n_q;
  assign bus.addr = addr_q;
  birc_fifo #(.WIDTH(`BIRC_DATA_W), .DEPTH(DEPTH)) u_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .in_valid_i(!bus.instr_ready_n),
    .in_ready_o(fifo_ready),
    .in_data_i(bus.instr),
    .out_valid_o(instr_valid_o),
    .out_ready_i(instr_ready_i),
    .out_data_o(instr_o)
  );
endmodule
`default_nettype wire

// file: bench/birc_monitor.sv
// Interface checker for the burst instruction memory controller
`timescale 1ns/1ps
`default_nettype none
`include "birc_params.svh"
module birc_monitor (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic instr_req_n,
  input wire logic burst_req_n,
  input wire logic burst_ack_n,
  input wire logic instr_ready_n,
  input wire logic invalidate_n,
  input wire logic [`BIRC_PADDR_W-1:0] addr,
  input wire logic mem_ce_n_o,
  input wire logic [`BIRC_WADDR_W-1:0] mem_addr_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_ack_delayed_copy: assert property (burst_ack_n == $past(burst_req_n)) else $error("ack not delayed copy");
  a_request_enters: assert property (instr_ready_n && !instr_req_n && invalidate_n |=> !instr_ready_n)
    else $error("no entry on request");
  a_burst_stays: assert property (!instr_ready_n && !burst_req_n |=> !instr_ready_n) else $error("burst dropped");
  a_burst_exits: assert property (!instr_ready_n && burst_req_n |=> instr_ready_n) else $error("no exit");
  a_invalid_blocks: assert property (instr_ready_n && !invalidate_n |=> instr_ready_n)
    else $error("entry while invalid");
  a_resume_enters: assert property (instr_ready_n && instr_req_n && !burst_req_n && invalidate_n |=> !instr_ready_n)
    else $error("no resume");
  a_ce_tracks_ready: assert property (mem_ce_n_o == instr_ready_n) else $error("enable differs from ready");
  a_addr_loads: assert property (instr_ready_n && !instr_req_n && invalidate_n |=>
    mem_addr_o == $past(addr[`BIRC_PADDR_W-1:2])) else $error("address not loaded");
  a_count_steps: assert property (!instr_ready_n |=>
    mem_addr_o == {$past(mem_addr_o[16:8]), 8'($past(mem_addr_o[7:0]) + 8'h01)}) else $error("count wrong");
  a_idle_holds: assert property (instr_ready_n && instr_req_n |=> $stable(mem_addr_o)) else $error("idle drift");
endmodule
`default_nettype wire

// file: bench/birc_tb.sv
// Testbench joining processor end and memory controller end
`timescale 1ns/1ps
`default_nettype none
`include "birc_params.svh"
module testbench;
  logic sys_clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic fetch = 1'h0;
  logic burst = 1'h0;
  logic cancel = 1'h0;
  logic rdy = 1'h0;
  logic [`BIRC_PADDR_W-1:0] faddr = 19'h0_0000;
  logic valid, ce_n;
  logic [`BIRC_DATA_W-1:0] instr, mdata;
  logic [`BIRC_WADDR_W-1:0] maddr;
  int bad_count = 0;
  int check_count = 0;
  always #2 sys_clk_i = ~sys_clk_i;
  birc_if bus ();
  // Deselected memory shows inverted data so stale words cannot pass
  assign mdata = ce_n ? ~{15'h0000, maddr} : {15'h0000, maddr};
  birc_ctrl i_birc_ctrl (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus(bus), .mem_ce_n_o(ce_n), .mem_addr_o(maddr),
    .mem_data_i(mdata));
  birc_cpu i_birc_cpu (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus(bus), .fetch_i(fetch), .burst_i(burst),
    .cancel_i(cancel), .fetch_addr_i(faddr), .instr_valid_o(valid), .instr_ready_i(rdy), .instr_o(instr));
  birc_monitor i_birc_monitor (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .instr_req_n(bus.instr_req_n),
    .burst_req_n(bus.burst_req_n), .burst_ack_n(bus.burst_ack_n), .instr_ready_n(bus.instr_ready_n),
    .invalidate_n(bus.invalidate_n), .addr(bus.addr), .mem_ce_n_o(ce_n), .mem_addr_o(maddr));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic tick();
    @(posedge sys_clk_i);
    #1;
  endtask
  task automatic issue(input logic [18:0] a, input logic b, input logic c);
    faddr = a;
    burst = b;
    cancel = c;
    fetch = 1'h1;
    tick();
    fetch = 1'h0;
  endtask
  // Bounded wait for one word; rdy left high for back-to-back pops
  task automatic pop(input logic [31:0] exp);
    int n = 0;
    rdy = 1'h1;
    while (valid !== 1'h1 && n < 40) begin
      tick();
      n++;
    end
    if (n == 40) begin
      chk("fetch wait", 32'h0000_0000, 32'h0000_0001);
      wrap_up();
    end else begin
      chk("instr", instr, exp);
      tick();
    end
  endtask
  task automatic quiet(input int cyc);
    int seen = 0;
    rdy = 1'h1;
    repeat (cyc) begin
      tick();
      if (valid === 1'h1) seen++;
    end
    chk("extra words", 32'(seen), 32'h0000_0000);
  endtask
  task automatic t_single();
    issue(19'h0_0D14, 1'h0, 1'h0);
    pop({15'h0000, 17'h0_0345});
    quiet(10);
  endtask
  // Stalled FIFO forces burst drop; start just below the five-bit carry
  task automatic t_burst();
    rdy = 1'h0;
    issue(19'h4_B078, 1'h1, 1'h0);
    repeat (30) tick();
    burst = 1'h0;
    for (int i = 0; i < `BIRC_FIFO_DEPTH; i++) pop({15'h0000, 17'h1_2C1E + 17'(i)});
  endtask
  // Burst request alone from idle resumes at the held counter; no word lost
  task automatic t_resume();
    rdy = 1'h0;
    burst = 1'h1;
    repeat (30) tick();
    burst = 1'h0;
    for (int i = 0; i < `BIRC_FIFO_DEPTH; i++) pop({15'h0000, 17'h1_2C26 + 17'(i)});
    quiet(5);
  endtask
  task automatic t_cancel();
    issue(19'h0_0100, 1'h0, 1'h1);
    quiet(10);
  endtask
  initial begin
    repeat (2) @(posedge sys_clk_i);
    #1 rst_i = 1'h0;
    chk("idle lines", {27'h000_0000, bus.instr_req_n, bus.burst_req_n, bus.burst_ack_n, bus.instr_ready_n, ce_n},
      32'h0000_001F);
    t_single();
    t_burst();
    t_resume();
    t_cancel();
    wrap_up();
  end
endmodule
`default_nettype wire
